// file: opc_top.sv
// Operation
// - Oscillator band field codes 0..3 pick 4-6, 6-8, 8-11, 11-15 MHz.
// - Band and trim fields preload from factory calibration after reset.
// - Trim field 27:16: upper six bits temperature, lower six bits process.
// - Divider field 9:8 divides output by 1, 2, 4 or 8.
// - On-request bit 0: PLL runs when enabled; 1: only while requested.
// - A peripheral request is ignored unless the PLL enable bit is set.
// - In standby the PLL stops unless the keep-running bit 6 is one.
// - PLL on/off takes several cycles; software polls the active status bit.
// - Ratio register 0x48: integer in 11:0, fraction in 19:16, rest unused.
module opc_top
  import opc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = PLL_SETTLE_CYC
)(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 clk_en,
  input  wire logic [AW-1:0]        awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [AW-1:0]        araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic                 wp_active,
  input  wire logic                 pll_clk_req,
  input  wire logic                 standby_sleep,
  input  wire logic [1:0]           factory_band,
  input  wire logic [11:0]          factory_trim,
  output opc_osc_cfg_t              osc_cfg,
  output logic [3:0]                osc_divide_factor,
  output logic                      pll_run,
  output logic                      pll_active_status,
  output opc_pll_ratio_t            pll_ratio,
  output logic                      irq
);

  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
  begin : g_chk
    $error("SETTLE_CYCLES must be 1..255");
  end

  typedef struct packed {
    logic            awready;
    logic            wready;
    logic            aw_held;
    logic            w_held;
    logic [AW-1:0]   awaddr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    logic [NIRQ-1:0] ien;
    logic [NIRQ-1:0] flags;
    logic [31:0]     xtal;
    logic [31:0]     xtal_slow;
    logic [31:0]     rc_slow;
    logic [31:0]     ulp;
    logic [31:0]     rc_mid;
    logic [31:0]     fll;
    logic [31:0]     pll_ctrl;
    logic [31:0]     ratio;
    logic            preload;
    logic            pll_run;
    logic            pll_act;
    logic [7:0]      settle_cnt;
    logic [3:0]      div_factor;
    logic            irq;
  } opc_state_t;

  localparam opc_state_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                    rc_mid: RC_MID_RST, preload: 1'b1,
                                    div_factor: 4'h8, default: '0};
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);

  opc_state_t st_r;
  opc_state_t st_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  logic            do_wr;
  logic [31:0]     wd_be;
  logic [NIRQ-1:0] clr;
  logic [NIRQ-1:0] set;
  logic            want;
  logic [31:0]     rd;
  logic            rd_err;
  logic            prot;

  always_comb
  begin
    st_nxt = st_r;
    clr    = '0;
    set    = '0;
    rd     = '0;
    rd_err = 1'b0;
    do_wr  = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    wd_be  = merge(32'h0000_0000, st_r.wdata, st_r.wstrb, 32'hFFFF_FFFF);
    prot   = 1'b0;

    // Factory values replace the reset constants on the first enabled edge
    if (st_r.preload)
    begin
      st_nxt.rc_mid[BAND_LSB +: 2]  = factory_band;
      st_nxt.rc_mid[TRIM_LSB +: 12] = factory_trim;
      st_nxt.preload = 1'b0;
    end

    if (awvalid && st_r.awready)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = awaddr;
    end
    if (wvalid && st_r.wready)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = wdata;
      st_nxt.wstrb  = wstrb;
    end
    if (st_r.bvalid && bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    if (do_wr)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = RESP_OKAY;
      case (st_r.awaddr & WORD_MASK)
        OFS_IEN_CLR:   st_nxt.ien = st_r.ien & ~wd_be[NIRQ-1:0];
        OFS_IEN_SET:   st_nxt.ien = st_r.ien | wd_be[NIRQ-1:0];
        OFS_FLAGS:     clr = wd_be[NIRQ-1:0];
        OFS_STATUS:    st_nxt.bresp = RESP_OKAY;
        OFS_XTAL:      st_nxt.xtal = merge(st_r.xtal, st_r.wdata, st_r.wstrb, MASK_W16);
        OFS_XTAL_SLOW: st_nxt.xtal_slow = merge(st_r.xtal_slow, st_r.wdata, st_r.wstrb, MASK_W16);
        OFS_RC_SLOW:   st_nxt.rc_slow = merge(st_r.rc_slow, st_r.wdata, st_r.wstrb, 32'hFFFF_FFFF);
        OFS_ULP:       st_nxt.ulp = merge(st_r.ulp, st_r.wdata, st_r.wstrb, MASK_W8);
        OFS_RC_MID:    st_nxt.rc_mid = merge(st_nxt.rc_mid, st_r.wdata, st_r.wstrb, MASK_RC_MID);
        OFS_FLL:       st_nxt.fll = merge(st_r.fll, st_r.wdata, st_r.wstrb, MASK_W16);
        OFS_PLL_CTRL,
        OFS_PLL_RATIO: prot = 1'b1;
        default:       st_nxt.bresp = RESP_SLVERR;
      endcase
      // Protected writes while wp_active leave contents alone and report an error
      if (prot && wp_active)
      begin
        st_nxt.bresp = RESP_SLVERR;
      end
      else if (prot && (st_r.awaddr & WORD_MASK) == OFS_PLL_CTRL)
      begin
        st_nxt.pll_ctrl = merge(st_r.pll_ctrl, st_r.wdata, st_r.wstrb, MASK_CTRL);
      end
      else if (prot)
      begin
        st_nxt.ratio = merge(st_r.ratio, st_r.wdata, st_r.wstrb, MASK_RATIO);
      end
    end
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;

    case (araddr & WORD_MASK)
      OFS_IEN_CLR,
      OFS_IEN_SET:   rd = 32'(st_r.ien);
      OFS_FLAGS:     rd = 32'(st_r.flags);
      OFS_STATUS:    rd = 32'(st_r.pll_act);
      OFS_XTAL:      rd = st_r.xtal;
      OFS_XTAL_SLOW: rd = st_r.xtal_slow;
      OFS_RC_SLOW:   rd = st_r.rc_slow;
      OFS_ULP:       rd = st_r.ulp;
      OFS_RC_MID:    rd = st_r.rc_mid;
      OFS_FLL:       rd = st_r.fll;
      OFS_PLL_CTRL:  rd = st_r.pll_ctrl;
      OFS_PLL_RATIO: rd = st_r.ratio;
      default:       rd_err = 1'b1;
    endcase
    if (st_r.rvalid && rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd;
      st_nxt.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // A request counts only with enable set; standby stops it unless kept
    want = st_r.pll_ctrl[EN_BIT]
           && (!st_r.pll_ctrl[REQ_BIT] || pll_clk_req)
           && (!standby_sleep || st_r.pll_ctrl[KEEP_BIT]);
    st_nxt.pll_run = want;

    // Status follows the run level only after it has held for the settle time
    if (st_r.pll_run != st_r.pll_act)
    begin
      if (st_r.settle_cnt == SETTLE_LAST)
      begin
        st_nxt.pll_act    = st_r.pll_run;
        st_nxt.settle_cnt = '0;
        set[IRQ_ON]       = st_r.pll_run;
        set[IRQ_OFF]      = !st_r.pll_run;
      end
      else
      begin
        st_nxt.settle_cnt = st_r.settle_cnt + 8'h01;
      end
    end
    else
    begin
      st_nxt.settle_cnt = '0;
    end

    // A new event outranks a clear in the same cycle
    st_nxt.flags      = (st_r.flags & ~clr) | set;
    st_nxt.irq        = |(st_nxt.flags & st_nxt.ien);
    st_nxt.div_factor = 4'h1 << st_nxt.rc_mid[DIV_LSB +: 2];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= ST_RST;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  assign awready  = st_r.awready;
  assign wready   = st_r.wready;
  assign bvalid   = st_r.bvalid;
  assign bresp    = st_r.bresp;
  assign arready  = st_r.arready;
  assign rvalid   = st_r.rvalid;
  assign rdata    = st_r.rdata;
  assign rresp    = st_r.rresp;
  assign osc_cfg.band         = st_r.rc_mid[BAND_LSB +: 2];
  assign osc_cfg.trim_temp    = st_r.rc_mid[TRIM_LSB + TRIM_HALF +: 6];
  assign osc_cfg.trim_process = st_r.rc_mid[TRIM_LSB +: 6];
  assign osc_cfg.divider      = st_r.rc_mid[DIV_LSB +: 2];
  assign osc_divide_factor    = st_r.div_factor;
  assign pll_run              = st_r.pll_run;
  assign pll_active_status    = st_r.pll_act;
  assign pll_ratio.integer_part  = st_r.ratio[11:0];
  assign pll_ratio.fraction_part = st_r.ratio[FRAC_LSB +: 4];
  assign irq                  = st_r.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  sequence s_prot_write;
    do_wr && wp_active && ((st_r.awaddr & WORD_MASK) == OFS_PLL_RATIO);
  endsequence

  sequence s_preload_done;
    $fell(st_r.preload);
  endsequence

  band_field_a: assert property (osc_cfg.band == st_r.rc_mid[31:30])
    else $error("band output differs from field");
  preload_cal_a: assert property (s_preload_done |-> osc_cfg.band == $past(factory_band)
                                  && {osc_cfg.trim_temp, osc_cfg.trim_process} == $past(factory_trim))
    else $error("calibration preload missing");
  trim_split_a: assert property ({osc_cfg.trim_temp, osc_cfg.trim_process} == st_r.rc_mid[27:16])
    else $error("trim split wrong");
  div_factor_a: assert property (osc_divide_factor == (4'h1 << st_r.rc_mid[9:8]))
    else $error("divide factor wrong");
  run_always_a: assert property (st_r.pll_ctrl[1] && !st_r.pll_ctrl[7] && !standby_sleep |=> pll_run)
    else $error("enabled pll not running");
  req_gated_a: assert property (!st_r.pll_ctrl[1] && pll_clk_req |=> !pll_run)
    else $error("request started disabled pll");
  standby_stop_a: assert property (standby_sleep && !st_r.pll_ctrl[6] |=> !pll_run)
    else $error("pll ran in standby");
  settle_time_a: assert property ($changed(pll_active_status) |-> $past(st_r.settle_cnt) == SETTLE_LAST
                                  && $past(pll_run) == pll_active_status)
    else $error("status changed before settle time");
  ratio_unused_a: assert property (st_r.ratio[31:20] == 12'h000 && st_r.ratio[15:12] == 4'h0)
    else $error("unused ratio bits set");
  ratio_locked_a: assert property (s_prot_write |=> $stable(st_r.ratio) ##1 $stable(pll_ratio))
    else $error("protected ratio write took effect");
  irq_level_a: assert property (irq == |(st_r.flags & st_r.ien))
    else $error("interrupt level wrong");

endmodule

// file: opc_pkg.sv
package opc_pkg;

  localparam int unsigned AW = 7;
  localparam logic [AW-1:0] OFS_IEN_CLR   = 7'h00;
  localparam logic [AW-1:0] OFS_IEN_SET   = 7'h04;
  localparam logic [AW-1:0] OFS_FLAGS     = 7'h08;
  localparam logic [AW-1:0] OFS_STATUS    = 7'h0C;
  localparam logic [AW-1:0] OFS_XTAL      = 7'h10;
  localparam logic [AW-1:0] OFS_XTAL_SLOW = 7'h14;
  localparam logic [AW-1:0] OFS_RC_SLOW   = 7'h18;
  localparam logic [AW-1:0] OFS_ULP       = 7'h1C;
  localparam logic [AW-1:0] OFS_RC_MID    = 7'h20;
  localparam logic [AW-1:0] OFS_FLL       = 7'h24;
  localparam logic [AW-1:0] OFS_PLL_CTRL  = 7'h44;
  localparam logic [AW-1:0] OFS_PLL_RATIO = 7'h48;
  localparam logic [AW-1:0] WORD_MASK     = 7'h7C;

  localparam logic [31:0] MASK_W16    = 32'h0000_FFFF;
  localparam logic [31:0] MASK_W8     = 32'h0000_00FF;
  localparam logic [31:0] MASK_RC_MID = 32'hCFFF_03C2;
  localparam logic [31:0] MASK_CTRL   = 32'h0000_00C2;
  localparam logic [31:0] MASK_RATIO  = 32'h000F_0FFF;
  localparam logic [31:0] RC_MID_RST  = 32'h0000_0382;

  localparam int unsigned BAND_LSB  = 30;
  localparam int unsigned TRIM_LSB  = 16;
  localparam int unsigned TRIM_HALF = 6;
  localparam int unsigned DIV_LSB   = 8;
  localparam int unsigned EN_BIT    = 1;
  localparam int unsigned KEEP_BIT  = 6;
  localparam int unsigned REQ_BIT   = 7;
  localparam int unsigned FRAC_LSB  = 16;
  localparam int unsigned NIRQ      = 2;
  localparam int unsigned IRQ_ON    = 0;
  localparam int unsigned IRQ_OFF   = 1;

  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned PLL_SETTLE_NS   = 64;
  localparam int unsigned PLL_SETTLE_CYC  = (PLL_SETTLE_NS * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0]  band;
    logic [5:0]  trim_temp;
    logic [5:0]  trim_process;
    logic [1:0]  divider;
  } opc_osc_cfg_t;

  typedef struct packed {
    logic [11:0] integer_part;
    logic [3:0]  fraction_part;
  } opc_pll_ratio_t;

endpackage

// file: opc_periph_model.sv
module opc_periph_model
#(
  parameter int LAG = 3
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic need,
  output logic      pll_clk_req
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Slow wake-up on request, immediate release when the need ends
  always @(posedge aclk)
  begin
    if (!aresetn || !need)
    begin
      cnt <= 0;
      pll_clk_req <= 1'b0;
    end
    else if (cnt < LAG)
      cnt <= cnt + 1;
    else
      pll_clk_req <= 1'b1;
  end
endmodule

// file: opc_top_test.sv
module opc_top_test
  import opc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic [AW-1:0]  awaddr = '0;
  logic [AW-1:0]  araddr = '0;
  logic           awvalid = 1'b0;
  logic           wvalid = 1'b0;
  logic           bready = 1'b0;
  logic           arvalid = 1'b0;
  logic           rready = 1'b0;
  logic [31:0]    wdata = '0;
  logic           wp_active = 1'b0;
  logic           clk_en = 1'b1;
  logic [3:0]     wstrb = 4'hF;
  logic           standby_sleep = 1'b0;
  logic           need = 1'b0;
  logic [1:0]     fb = 2'h0;
  logic [11:0]    ft = 12'h000;
  logic           awready, wready, bvalid, arready, rvalid;
  logic           pll_clk_req, pll_run, pll_active_status, irq;
  logic [1:0]     bresp, rresp;
  logic [31:0]    rdata, v;
  logic [3:0]     osc_divide_factor;
  opc_osc_cfg_t   osc_cfg;
  opc_pll_ratio_t pll_ratio;
  logic [33:0]    e;
  logic [33:0]    rq[$];
  logic [1:0]     bq[$];
  logic [31:0]    seed = 32'h42C8;
  int             n_errors = 0;
  int             tests_run = 0;
  int             k;

  opc_top #(.SETTLE_CYCLES(2)) dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .wp_active(wp_active), .pll_clk_req(pll_clk_req),
    .standby_sleep(standby_sleep), .factory_band(fb), .factory_trim(ft), .osc_cfg(osc_cfg),
    .osc_divide_factor(osc_divide_factor), .pll_run(pll_run),
    .pll_active_status(pll_active_status), .pll_ratio(pll_ratio), .irq(irq));

  opc_periph_model #(.LAG(3)) periph_u (.aclk(aclk), .aresetn(aresetn), .need(need),
    .pll_clk_req(pll_clk_req));

  initial forever #4 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] r);
    logic pa, pw;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (pa && awready === 1'b1)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Results are judged in order of arrival, not by the driver
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      e = rq.pop_front();
      check(rdata, e[31:0]);
      check({30'h0, rresp}, {30'h0, e[33:32]});
    end
    if (bvalid === 1'b1 && bready === 1'b1)
      check({30'h0, bresp}, {30'h0, bq.pop_front()});
  end

  initial
  begin
    repeat (6000) @(posedge aclk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    seed = lfsr(seed);
    fb = seed[13:12];
    ft = seed[11:0];
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    check(32'(osc_divide_factor), 32'h8);
    check(32'(osc_cfg), 32'({fb, ft, 2'h3}));
    rd(OFS_RC_MID, RC_MID_RST | {fb, 2'h0, ft, 16'h0000}, RESP_OKAY);
    rd(OFS_PLL_RATIO, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      v = {2'(i), seed[29:10], 2'(3 - i), seed[7:0]};
      wr(OFS_RC_MID, v, RESP_OKAY);
      rd(OFS_RC_MID, v & MASK_RC_MID, RESP_OKAY);
      cyc(1);
      check(32'(osc_cfg), 32'({v[31:30], v[27:16], v[9:8]}));
      check(32'(osc_divide_factor), 32'h1 << v[9:8]);
    end
    // Only byte lane 1 may land: divider goes to 3, the rest stays
    @(posedge aclk);
    wstrb <= 4'h2;
    wr(OFS_RC_MID, 32'hFFFF_FFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_RC_MID, (v & MASK_RC_MID) | 32'h0000_0300, RESP_OKAY);
    cyc(1);
    check(32'(osc_divide_factor), 32'h8);
    wr(OFS_PLL_RATIO, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_PLL_RATIO, MASK_RATIO, RESP_OKAY);
    cyc(1);
    check(32'(pll_ratio), 32'h0000_FFFF);
    @(posedge aclk);
    wp_active <= 1'b1;
    wr(OFS_PLL_RATIO, 32'h0001_1234, RESP_SLVERR);
    wr(OFS_PLL_CTRL, 32'h2, RESP_SLVERR);
    rd(OFS_PLL_RATIO, MASK_RATIO, RESP_OKAY);
    wp_active <= 1'b0;
    rd(7'h30, 32'h0, RESP_SLVERR);
    wr(7'h30, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    wr(OFS_IEN_SET, 32'h3, RESP_OKAY);
    rd(OFS_IEN_CLR, 32'h3, RESP_OKAY);
    wr(OFS_PLL_CTRL, 32'h2, RESP_OKAY);
    cyc(0);
    check({31'h0, pll_active_status}, 32'h0);
    cyc(2);
    check({31'h0, pll_run}, 32'h1);
    k = 0;
    while (pll_active_status !== 1'b1 && k < 40)
    begin
      cyc(1);
      k++;
    end
    check({31'h0, pll_active_status}, 32'h1);
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    rd(OFS_FLAGS, 32'h1, RESP_OKAY);
    cyc(2);
    check({31'h0, irq}, 32'h1);
    wr(OFS_IEN_CLR, 32'h1, RESP_OKAY);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    wr(OFS_FLAGS, 32'h1, RESP_OKAY);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    wr(OFS_PLL_CTRL, 32'h82, RESP_OKAY);
    cyc(3);
    check({31'h0, pll_run}, 32'h0);
    // Frozen by the enable, a fresh request must not reach the run level
    @(posedge aclk);
    clk_en <= 1'b0;
    need <= 1'b1;
    k = 0;
    while (pll_clk_req !== 1'b1 && k < 20)
    begin
      cyc(1);
      k++;
    end
    check({31'h0, pll_clk_req}, 32'h1);
    cyc(2);
    check({31'h0, pll_run}, 32'h0);
    @(posedge aclk);
    clk_en <= 1'b1;
    cyc(2);
    check({31'h0, pll_run}, 32'h1);
    wr(OFS_PLL_CTRL, 32'h80, RESP_OKAY);
    cyc(2);
    check({31'h0, pll_run}, 32'h0);
    @(posedge aclk);
    need <= 1'b0;
    standby_sleep <= 1'b1;
    wr(OFS_PLL_CTRL, 32'h2, RESP_OKAY);
    cyc(3);
    check({31'h0, pll_run}, 32'h0);
    wr(OFS_PLL_CTRL, 32'h42, RESP_OKAY);
    cyc(2);
    check({31'h0, pll_run}, 32'h1);
    cyc(2);
    report_and_stop();
  end
endmodule
